// ===== hw/mses_pkg.sv
package mses_pkg;
   // midi status nibbles
   localparam logic [3:0] MSES_ST_CC = 4'hB;
   localparam logic [3:0] MSES_ST_PC = 4'hC;
   // channel numbers on the wire are zero based
   localparam logic [3:0] MSES_CH_SCENE = 4'hE;
   localparam logic [3:0] MSES_CH_FX1 = 4'h0;
   localparam logic [3:0] MSES_CH_FX2 = 4'h1;
   // controller numbers for bank select
   localparam logic [6:0] MSES_CC_BANK_MSB = 7'h00;
   localparam logic [6:0] MSES_CC_BANK_LSB = 7'h20;
   // wire program value 0 means program number 1
   localparam logic [6:0] MSES_SCENE_PROG_MAX = 7'h07;
   localparam logic [6:0] MSES_PATCH_PROG_MAX = 7'h63;
   localparam logic [1:0] MSES_BANK_MAX = 2'h2;
   // serial link: 31250 baud at 50 MHz
   localparam int MSES_CLK_HZ = 50000000;
   localparam int MSES_BAUD = 31250;
   localparam int MSES_BIT_CYC = MSES_CLK_HZ / MSES_BAUD;
   localparam int MSES_HALF_CYC = MSES_BIT_CYC / 2;
   localparam logic [6:0] MSES_BANK_RST = 7'h00;

   typedef enum logic [1:0] {
      MSES_BANK_A,
      MSES_BANK_B,
      MSES_BANK_U
   } mses_bank_t;

   typedef struct packed {
      mses_bank_t bank;
      logic [6:0] patch;
   } mses_patch_t;

   typedef struct packed {
      logic [3:0] channel;
      logic [6:0] number;
      logic [6:0] value;
   } mses_cc_t;
endpackage

// ===== hw/mses_uart_rx.sv
`timescale 1ns/1ps
module mses_uart_rx (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // serial input, idle high
   input wire logic midi_rx,
   // received byte
   output logic [7:0] rx_data,
   output logic rx_valid
);
   import mses_pkg::*;

   typedef enum logic [1:0] {
      MSES_RX_IDLE,
      MSES_RX_START,
      MSES_RX_DATA,
      MSES_RX_STOP
   } mses_rx_state_t;

   mses_rx_state_t state_reg, state_next;
   logic [11:0] cnt_reg, cnt_next;
   logic [2:0] bit_reg, bit_next;
   logic [7:0] shift_reg, shift_next;
   logic [7:0] data_reg, data_next;
   logic valid_reg, valid_next;

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      bit_next = bit_reg;
      shift_next = shift_reg;
      data_next = data_reg;
      valid_next = 1'b0;
      case (state_reg)
         MSES_RX_IDLE: begin
            cnt_next = 12'h000;
            if (!midi_rx) begin
               state_next = MSES_RX_START;
            end
         end
         MSES_RX_START: begin
            // recheck at mid start bit, rejects glitches
            if (cnt_reg == 12'(MSES_HALF_CYC - 1)) begin
               cnt_next = 12'h000;
               bit_next = 3'h0;
               state_next = midi_rx ? MSES_RX_IDLE : MSES_RX_DATA;
            end else begin
               cnt_next = cnt_reg + 12'h001;
            end
         end
         MSES_RX_DATA: begin
            if (cnt_reg == 12'(MSES_BIT_CYC - 1)) begin
               cnt_next = 12'h000;
               shift_next = {midi_rx, shift_reg[7:1]};
               bit_next = bit_reg + 3'h1;
               if (bit_reg == 3'h7) begin
                  state_next = MSES_RX_STOP;
               end
            end else begin
               cnt_next = cnt_reg + 12'h001;
            end
         end
         MSES_RX_STOP: begin
            if (cnt_reg == 12'(MSES_BIT_CYC - 1)) begin
               state_next = MSES_RX_IDLE;
               // framing error drops the byte
               if (midi_rx) begin
                  data_next = shift_reg;
                  valid_next = 1'b1;
               end
            end else begin
               cnt_next = cnt_reg + 12'h001;
            end
         end
         default: state_next = MSES_RX_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= MSES_RX_IDLE;
         cnt_reg <= 12'h000;
         bit_reg <= 3'h0;
         shift_reg <= 8'h00;
         data_reg <= 8'h00;
         valid_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         bit_reg <= bit_next;
         shift_reg <= shift_next;
         data_reg <= data_next;
         valid_reg <= valid_next;
      end
   end

   assign rx_data = data_reg;
   assign rx_valid = valid_reg;
endmodule

// ===== hw/mses_top.sv
// Functional notes
// [R01] scene program-change selection acts only while scene enable is on
// [R02] scene program changes are accepted only on midi channel 15
// [R03] program numbers 1-8 select scenes 1-8 one to one
// [R04] during playback: stop, switch scene, then resume, in order
// [R05] while recording every program change is ignored
// [R06] effect patch selection acts only while effect enable is on
// [R07] channel 1 drives first effect unit, channel 2 the second
// [R08] bank lsb 0/1/2 with msb 0 picks A/B/U, programs 1-100 map 00-99
// [R09] control changes pass to effects only while control enable is on
// [R10] controller should switch effects with nrpn sequences; no nrpn is decoded, effects switch by bank select plus program change
// [R11] other channels or out-of-range programs change nothing
`timescale 1ns/1ps
module mses_top (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // serial midi input
   input wire logic midi_rx,
   // settings
   input wire logic scene_program_select_enable,
   input wire logic effect_program_select_enable,
   input wire logic effect_control_change_enable,
   // transport
   input wire logic playing,
   input wire logic recording,
   input wire logic transport_stopped,
   output logic play_stop_req,
   output logic play_resume_req,
   // scene
   output logic [2:0] scene_index,
   output logic scene_load,
   // effects
   output mses_pkg::mses_patch_t first_effect_unit_patch,
   output logic first_effect_unit_load,
   output mses_pkg::mses_patch_t second_effect_unit_patch,
   output logic second_effect_unit_load,
   output mses_pkg::mses_cc_t effect_cc,
   output logic effect_cc_valid
);
   import mses_pkg::*;

   typedef enum logic [2:0] {
      MSES_SC_IDLE,
      MSES_SC_STOP,
      MSES_SC_WAIT,
      MSES_SC_LOAD,
      MSES_SC_RESUME
   } mses_scene_state_t;

   logic [7:0] rx_data;
   logic rx_valid;

   mses_uart_rx u_rx (
      .clk(clk),
      .sys_rst(sys_rst),
      .midi_rx(midi_rx),
      .rx_data(rx_data),
      .rx_valid(rx_valid)
   );

   // true for the two effect unit channels, whose bank select is tracked per channel
   function automatic logic fx_chan(input logic [3:0] ch);
      fx_chan = (ch == MSES_CH_FX1) || (ch == MSES_CH_FX2);
   endfunction

   // running status parser
   logic [3:0] stat_reg, stat_next;
   logic [3:0] chan_reg, chan_next;
   logic have1_reg, have1_next;
   logic [6:0] d1_reg, d1_next;
   logic [6:0] msb_reg [2], msb_next [2];
   logic [6:0] lsb_reg [2], lsb_next [2];
   mses_patch_t patch_reg [2], patch_next [2];
   logic load_reg [2], load_next [2];
   mses_cc_t cc_reg, cc_next;
   logic cc_v_reg, cc_v_next;
   mses_scene_state_t sc_reg, sc_next;
   logic [2:0] scene_reg, scene_next, pend_reg, pend_next;
   logic scene_ld_reg, scene_ld_next;
   logic stop_reg, stop_next, resume_reg, resume_next;

   logic pc_done, cc_done;
   logic [6:0] prog;
   logic u;

   always_comb begin
      stat_next = stat_reg;
      chan_next = chan_reg;
      have1_next = have1_reg;
      d1_next = d1_reg;
      msb_next = msb_reg;
      lsb_next = lsb_reg;
      patch_next = patch_reg;
      load_next = '{1'b0, 1'b0};
      cc_next = cc_reg;
      cc_v_next = 1'b0;
      sc_next = sc_reg;
      scene_next = scene_reg;
      pend_next = pend_reg;
      scene_ld_next = 1'b0;
      stop_next = 1'b0;
      resume_next = 1'b0;
      pc_done = 1'b0;
      cc_done = 1'b0;
      prog = rx_data[6:0];
      u = (chan_reg == MSES_CH_FX2);
      if (rx_valid) begin
         if (rx_data[7]) begin
            // realtime bytes leave running status alone
            if (rx_data[7:3] != 5'h1F) begin
               stat_next = rx_data[7:4];
               chan_next = rx_data[3:0];
               have1_next = 1'b0;
            end
         end else if (stat_reg == MSES_ST_PC) begin
            pc_done = 1'b1;
         end else if (stat_reg == MSES_ST_CC) begin
            if (!have1_reg) begin
               d1_next = rx_data[6:0];
               have1_next = 1'b1;
            end else begin
               have1_next = 1'b0;
               cc_done = 1'b1;
            end
         end
      end
      // bank select is tracked for effect channels regardless of enables
      if (cc_done && fx_chan(chan_reg)) begin
         if (d1_reg == MSES_CC_BANK_MSB) begin
            msb_next[u] = prog;
         end
         if (d1_reg == MSES_CC_BANK_LSB) begin
            lsb_next[u] = prog;
         end
      end
      if (cc_done && effect_control_change_enable) begin // [R09]
         cc_next = '{channel: chan_reg, number: d1_reg, value: prog};
         cc_v_next = 1'b1;
      end
      // [R05] recording blocks every program change
      if (pc_done && !recording) begin
         if (effect_program_select_enable && fx_chan(chan_reg)) begin // [R06] [R07]
            if (msb_reg[u] == MSES_BANK_RST && lsb_reg[u][6:2] == 5'h00 &&
                lsb_reg[u][1:0] <= MSES_BANK_MAX && prog <= MSES_PATCH_PROG_MAX) begin // [R08] [R11]
               patch_next[u] = '{bank: mses_bank_t'(lsb_reg[u][1:0]), patch: prog};
               load_next[u] = 1'b1;
            end
         end
         if (scene_program_select_enable && chan_reg == MSES_CH_SCENE && // [R01] [R02]
             prog <= MSES_SCENE_PROG_MAX && sc_reg == MSES_SC_IDLE) begin // [R11]
            pend_next = prog[2:0]; // [R03]
            sc_next = playing ? MSES_SC_STOP : MSES_SC_LOAD;
         end
      end
      // [R04] pause, switch, resume
      case (sc_reg)
         MSES_SC_IDLE: ;
         MSES_SC_STOP: begin
            stop_next = 1'b1;
            sc_next = MSES_SC_WAIT;
         end
         MSES_SC_WAIT: begin
            if (transport_stopped) begin
               scene_next = pend_reg;
               scene_ld_next = 1'b1;
               sc_next = MSES_SC_RESUME;
            end
         end
         MSES_SC_LOAD: begin
            scene_next = pend_reg;
            scene_ld_next = 1'b1;
            sc_next = MSES_SC_IDLE;
         end
         MSES_SC_RESUME: begin
            resume_next = 1'b1;
            sc_next = MSES_SC_IDLE;
         end
         default: sc_next = MSES_SC_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         stat_reg <= 4'h0;
         chan_reg <= 4'h0;
         have1_reg <= 1'b0;
         d1_reg <= 7'h00;
         msb_reg <= '{MSES_BANK_RST, MSES_BANK_RST};
         lsb_reg <= '{MSES_BANK_RST, MSES_BANK_RST};
         patch_reg <= '{'0, '0};
         load_reg <= '{1'b0, 1'b0};
         cc_reg <= '0;
         cc_v_reg <= 1'b0;
         sc_reg <= MSES_SC_IDLE;
         scene_reg <= 3'h0;
         pend_reg <= 3'h0;
         scene_ld_reg <= 1'b0;
         stop_reg <= 1'b0;
         resume_reg <= 1'b0;
      end else begin
         stat_reg <= stat_next;
         chan_reg <= chan_next;
         have1_reg <= have1_next;
         d1_reg <= d1_next;
         msb_reg <= msb_next;
         lsb_reg <= lsb_next;
         patch_reg <= patch_next;
         load_reg <= load_next;
         cc_reg <= cc_next;
         cc_v_reg <= cc_v_next;
         sc_reg <= sc_next;
         scene_reg <= scene_next;
         pend_reg <= pend_next;
         scene_ld_reg <= scene_ld_next;
         stop_reg <= stop_next;
         resume_reg <= resume_next;
      end
   end

   assign first_effect_unit_patch = patch_reg[0];
   assign first_effect_unit_load = load_reg[0];
   assign second_effect_unit_patch = patch_reg[1];
   assign second_effect_unit_load = load_reg[1];
   assign effect_cc = cc_reg;
   assign effect_cc_valid = cc_v_reg;
   assign scene_index = scene_reg;
   assign scene_load = scene_ld_reg;
   assign play_stop_req = stop_reg;
   assign play_resume_req = resume_reg;
endmodule

// ===== tb/mses_top_checker.sv
`timescale 1ns/1ps
module mses_top_checker (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // settings and transport
   input wire logic scene_program_select_enable,
   input wire logic effect_program_select_enable,
   input wire logic effect_control_change_enable,
   input wire logic recording,
   input wire logic transport_stopped,
   // watched outputs
   input wire logic play_stop_req,
   input wire logic play_resume_req,
   input wire logic [2:0] scene_index,
   input wire logic scene_load,
   input wire mses_pkg::mses_patch_t first_effect_unit_patch,
   input wire logic first_effect_unit_load,
   input wire logic second_effect_unit_load,
   input wire logic effect_cc_valid
);
   import mses_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   sequence s_halted;
      play_stop_req ##[1:20] $rose(transport_stopped);
   endsequence
   sequence s_switch;
      scene_load ##1 play_resume_req;
   endsequence
   a_stop_pulse: assert property (play_stop_req |=> !play_stop_req)
      else $error("stop request too long");
   a_switch_order: assert property (s_halted |=> s_switch)
      else $error("no switch and resume after halt");
   a_resume_cause: assert property (play_resume_req |-> $past(scene_load))
      else $error("resume without switch");
   a_scene_gate: assert property (scene_load |-> $past(transport_stopped)
      || ($past(scene_program_select_enable, 2) && !$past(recording, 2)))
      else $error("scene switched while blocked");
   a_index_cause: assert property ($changed(scene_index) |-> scene_load)
      else $error("index moved without load");
   a_fx1_gate: assert property (first_effect_unit_load |->
      $past(effect_program_select_enable) && !$past(recording))
      else $error("first unit loaded while blocked");
   a_fx2_gate: assert property (second_effect_unit_load |->
      $past(effect_program_select_enable) && !$past(recording))
      else $error("second unit loaded while blocked");
   a_patch_range: assert property (first_effect_unit_load |->
      first_effect_unit_patch.patch <= MSES_PATCH_PROG_MAX
      && first_effect_unit_patch.bank <= MSES_BANK_U)
      else $error("patch out of range");
   a_cc_gate: assert property (effect_cc_valid |-> $past(effect_control_change_enable))
      else $error("cc passed while disabled");
endmodule
bind mses_top mses_top_checker chk (
   .clk(clk), .sys_rst(sys_rst), .recording(recording),
   .scene_program_select_enable(scene_program_select_enable),
   .effect_program_select_enable(effect_program_select_enable),
   .effect_control_change_enable(effect_control_change_enable),
   .transport_stopped(transport_stopped), .play_stop_req(play_stop_req),
   .play_resume_req(play_resume_req), .scene_index(scene_index), .scene_load(scene_load),
   .first_effect_unit_patch(first_effect_unit_patch),
   .first_effect_unit_load(first_effect_unit_load),
   .second_effect_unit_load(second_effect_unit_load), .effect_cc_valid(effect_cc_valid)
);

// ===== tb/mses_midi_ctrl.sv
`timescale 1ns/1ps
module mses_midi_ctrl (
   // clock
   input wire logic clk,
   // serial line, idle high
   output logic midi_rx
);
   import mses_pkg::*;
   // plain channel messages only; effect switching by cc would need nrpn sequences
   initial midi_rx = 1'b1;
   // 8n1, lsb first; stop cut just past its centre to keep the run short
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] frame;
      frame = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(negedge clk);
         midi_rx = frame[i];
         repeat (i == 9 ? MSES_HALF_CYC + 100 : MSES_BIT_CYC - 1) @(negedge clk);
      end
   endtask
endmodule

// ===== tb/mses_top_tb.sv
`timescale 1ns/1ps
module mses_top_tb;
   import mses_pkg::*;
   typedef struct packed {
      logic [7:0] data;
      logic sen;
      logic rec;
      logic [3:0] sc_n;
      logic [2:0] idx;
      logic [3:0] fx_n;
      mses_patch_t patch;
   } mses_row_t;
   // fx status, patch 100, scene status, scene 8, scene off, recording
   // scene rows last: the playing test reuses their running status, a frame is ~15k cycles
   mses_row_t rows [6] = '{
      '{8'hC0, 1'b1, 1'b0, 4'h0, 3'h0, 4'h0, 9'h000},
      '{8'h63, 1'b1, 1'b0, 4'h0, 3'h0, 4'h1, 9'h063},
      '{8'hCE, 1'b1, 1'b0, 4'h0, 3'h0, 4'h1, 9'h063},
      '{8'h07, 1'b1, 1'b0, 4'h1, 3'h7, 4'h1, 9'h063},
      '{8'h00, 1'b0, 1'b0, 4'h1, 3'h7, 4'h1, 9'h063},
      '{8'h02, 1'b1, 1'b1, 4'h1, 3'h7, 4'h1, 9'h063}
   };
   logic clk;
   logic sys_rst;
   logic midi_rx;
   logic sc_en;
   logic fx_en = 1'b1;
   logic cc_en = 1'b1;
   logic playing;
   logic recording;
   logic transport_stopped = 1'b0;
   logic stop_req, resume_req, scene_load, fx1_load, fx2_load, cc_valid;
   logic [2:0] scene_index;
   mses_patch_t fx1_patch, fx2_patch;
   mses_cc_t cc;
   int bad_count = 0, comparisons = 0, cyc = 0, ts_cnt = 0;
   int n_scene = 0, n_fx1 = 0, n_fx2 = 0, n_cc = 0, n_stop = 0, n_res = 0;
   int t_stop = 0, t_load = 0, t_res = 0;

   mses_top dut (
      .clk(clk), .sys_rst(sys_rst), .midi_rx(midi_rx),
      .scene_program_select_enable(sc_en), .effect_program_select_enable(fx_en),
      .effect_control_change_enable(cc_en), .playing(playing), .recording(recording),
      .transport_stopped(transport_stopped), .play_stop_req(stop_req),
      .play_resume_req(resume_req), .scene_index(scene_index), .scene_load(scene_load),
      .first_effect_unit_patch(fx1_patch), .first_effect_unit_load(fx1_load),
      .second_effect_unit_patch(fx2_patch), .second_effect_unit_load(fx2_load),
      .effect_cc(cc), .effect_cc_valid(cc_valid)
   );
   mses_midi_ctrl ctrl (.clk(clk), .midi_rx(midi_rx));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // pulse monitor and transport model; sampled mid cycle where outputs are settled
   always @(negedge clk) begin
      cyc++;
      if (scene_load === 1'b1) t_load = cyc;
      if (scene_load === 1'b1) n_scene++;
      if (fx1_load === 1'b1) n_fx1++;
      if (fx2_load === 1'b1) n_fx2++;
      if (cc_valid === 1'b1) n_cc++;
      if (stop_req === 1'b1) t_stop = cyc;
      if (stop_req === 1'b1) n_stop++;
      if (resume_req === 1'b1) t_res = cyc;
      if (resume_req === 1'b1) n_res++;
      if (stop_req === 1'b1) ts_cnt = 1;
      else if (resume_req === 1'b1) ts_cnt = 0;
      else if (ts_cnt inside {[1:4]}) ts_cnt++;
      transport_stopped = (ts_cnt == 5);
   end

   task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      sys_rst = 1'b1;
      sc_en = 1'b1;
      playing = 1'b0;
      recording = 1'b0;
      repeat (12) @(negedge clk);
      chk("outputs in reset", {scene_index, scene_load, stop_req, resume_req, fx1_patch,
         fx1_load, fx2_patch, fx2_load, cc, cc_valid}, 64'h0);
      sys_rst = 1'b0;
      $display("reset test done");
      for (int i = 0; i < 6; i++) begin
         sc_en = rows[i].sen;
         recording = rows[i].rec;
         ctrl.send_byte(rows[i].data);
         repeat (10) @(negedge clk);
         chk("scene loads", n_scene, rows[i].sc_n);
         chk("scene index", scene_index, rows[i].idx);
         chk("patch loads", n_fx1, rows[i].fx_n);
         chk("patch", fx1_patch, rows[i].patch);
         chk("second unit loads", n_fx2, 0);
         chk("cc passes", n_cc, 0);
         chk("stop count idle", n_stop, 0);
         $display("row %0d done", i);
      end
      // scene channel running status still holds from the rows
      recording = 1'b0;
      playing = 1'b1;
      ctrl.send_byte(8'h04);
      repeat (20) @(negedge clk);
      chk("stop count", n_stop, 1);
      chk("resume count", n_res, 1);
      chk("scene loads", n_scene, 2);
      chk("scene index", scene_index, 3'h4);
      chk("halt order", {t_stop < t_load, t_load < t_res}, 2'b11);
      $display("playing test done");
      // second reset in mid run must clear the held selections
      sys_rst = 1'b1;
      repeat (3) @(negedge clk);
      sys_rst = 1'b0;
      chk("index after reset", scene_index, 3'h0);
      chk("patch after reset", fx1_patch, 9'h000);
      chk("second patch after reset", fx2_patch, 9'h000);
      chk("cc after reset", cc, 18'h00000);
      $display("mid reset test done");
      stop_test;
   end

   // seven frames of about 15300 cycles each, plus margin
   initial begin
      repeat (115000) @(posedge clk);
      bad_count++;
      $display("BAD watchdog expected finish seen hang");
      stop_test;
   end
endmodule
